// ### srr_pkg.sv
package srr_pkg;

  // ---------------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------------
  localparam int          REG_W          = 8;
  localparam logic [7:0]  STD_RESET      = 8'h80;
  localparam logic [7:0]  EVT_RESET      = 8'h00;
  localparam logic [7:0]  MASK_RESET     = 8'h00;

  // ---------------------------------------------------------------------
  // Status summary byte bit positions
  // ---------------------------------------------------------------------
  localparam int          SUM_CHB        = 1;
  localparam int          SUM_CHA        = 2;
  localparam int          SUM_FLT        = 3;
  localparam int          SUM_MSG        = 4;
  localparam int          SUM_STD        = 5;
  localparam int          SUM_RQS        = 6;

  // ---------------------------------------------------------------------
  // Standard event flag bit positions
  // ---------------------------------------------------------------------
  localparam int          STD_OPC        = 0;
  localparam int          STD_QUERY      = 2;
  localparam int          STD_EXEC       = 4;
  localparam int          STD_CMD        = 5;
  localparam int          STD_PON        = 7;

  // ---------------------------------------------------------------------
  // Channel event bit positions and error code range
  // ---------------------------------------------------------------------
  localparam int          CH_POSITIONED  = 5;
  localparam int          CH_RANGE       = 6;
  localparam logic [2:0]  CODE_FIRST     = 3'h1;
  localparam logic [2:0]  CODE_LAST      = 3'h5;

  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_RD_SUM,
    CMD_RD_STD,
    CMD_RD_FLT,
    CMD_RD_CHA,
    CMD_RD_CHB,
    CMD_WR_STD_EN,
    CMD_WR_FLT_EN,
    CMD_WR_CHA_EN,
    CMD_WR_CHB_EN,
    CMD_WR_SRQ_EN,
    CMD_RD_STD_EN,
    CMD_RD_FLT_EN,
    CMD_RD_CHA_EN,
    CMD_RD_CHB_EN,
    CMD_RD_SRQ_EN
  } srr_cmd_type;

  // Fault causes, one per system fault bit 0..7
  typedef struct packed {
    logic unknown_b;
    logic unknown_a;
    logic nvm_fail;
    logic hold_fail;
    logic config_change;
    logic restart_wait;
    logic over_temp;
    logic drive_fail;
  } srr_fault_type;

  typedef struct packed {
    logic       code_valid;
    logic [2:0] code;
    logic       positioned;
    logic       out_of_range;
  } srr_chan_type;

endpackage

// ### srr_top.sv
`timescale 1ns/1ns

//Function
//(RL1) Summary bit 1 set when any enabled channel B event bit is set
//(RL2) Summary bit 2 set when any enabled channel A event bit is set
//(RL3) Summary bit 3 set when any enabled system fault bit is set
//(RL4) Summary bit 4 set while unread response data waits in the queue
//(RL5) Summary bit 5 set when any enabled standard event bit is set
//(RL6) Summary bit 6 and service request raised when enabled summary bit set
//(RL7) Standard event bit 0 set when an operation-complete command finishes
//(RL8) Standard event bit 2 set when addressed to talk with empty queue
//(RL9) Standard event bit 4 set when a command cannot be executed
//(RL10) Standard event bit 5 set when a command has bad syntax
//(RL11) Standard event bit 7 set after power-on until register is read
//(RL12) Fault bit 0 on drive supply failure, bit 4 on holding supply failure
//(RL13) Fault bit 1 when halted by chassis over-temperature
//(RL14) Fault bit 2 when power-on reset disabled and waiting for command
//(RL15) Fault bit 3 when an instrument is connected or removed
//(RL16) Fault bit 5 when settings memory is inaccessible or corrupt
//(RL17) Fault bits 6 and 7 when channel A or B instrument unknown
//(RL18) Channel A error codes 1 to 5 map to bits 0 to 4
//(RL19) Channel A bit 5 set when positioning finishes
//(RL20) Channel bit 6 on out-of-range request, which also resets the channel
//(RL21) Channel B event register uses the same layout as channel A
//(RL22) Each event register clears when the host reads it
//(RL23) Host writes and reads back 8-bit enable masks
//(RL24) Event bits stay set until their register is read
module srr_top
  import srr_pkg::*;
(
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic          ce_in,
  input  wire logic          cmd_valid_in,
  input  wire srr_cmd_type   cmd_in,
  input  wire logic [7:0]    cmd_data_in,
  input  wire logic          opc_done_in,
  input  wire logic          talk_req_in,
  input  wire logic          msg_avail_in,
  input  wire logic          exec_err_in,
  input  wire logic          syntax_err_in,
  input  wire srr_fault_type fault_in,
  input  wire srr_chan_type  chan_a_in,
  input  wire srr_chan_type  chan_b_in,
  output logic               rsp_valid_out,
  output logic [7:0]         rsp_data_out,
  output logic [7:0]         status_byte_out,
  output logic               srq_out,
  output logic               chan_a_reset_out,
  output logic               chan_b_reset_out
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] std_flags;
    logic [7:0] fault_events;
    logic [7:0] cha_events;
    logic [7:0] chb_events;
    logic [7:0] std_enable;
    logic [7:0] fault_enable;
    logic [7:0] cha_enable;
    logic [7:0] chb_enable;
    logic [7:0] srq_enable;
    logic [7:0] status_byte;
    logic       srq;
    logic       rsp_valid;
    logic [7:0] rsp_data;
    logic       cha_reset;
    logic       chb_reset;
  } srr_state_type;

  srr_state_type state_q;
  srr_state_type state_d;

  logic [7:0] std_ev;
  logic [7:0] fault_ev;
  logic [7:0] cha_ev;
  logic [7:0] chb_ev;
  logic       rd_std;
  logic       rd_flt;
  logic       rd_cha;
  logic       rd_chb;

  // ---------------------------------------------------------------------
  // Event decoding
  // ---------------------------------------------------------------------
  // Turns one channel's reports into its event bits
  function automatic logic [7:0] chan_events(input srr_chan_type ch);
    logic [7:0] ev;
    ev = 8'h00;
    if (ch.code_valid && ch.code >= CODE_FIRST && ch.code <= CODE_LAST) begin
      ev[ch.code - CODE_FIRST] = 1'b1;
    end
    ev[CH_POSITIONED] = ch.positioned;
    ev[CH_RANGE]      = ch.out_of_range;
    return ev;
  endfunction

  always_comb begin
    std_ev             = 8'h00;
    std_ev[STD_OPC]    = opc_done_in;                    // RL7
    std_ev[STD_QUERY]  = talk_req_in && !msg_avail_in;   // RL8
    std_ev[STD_EXEC]   = exec_err_in;                    // RL9
    std_ev[STD_CMD]    = syntax_err_in;                  // RL10
  end

  // One fault input per bit, in bit order
  assign fault_ev = fault_in;                 // RL12 RL13 RL14 RL15 RL16 RL17
  assign cha_ev   = chan_events(chan_a_in);   // RL18 RL19 RL20
  assign chb_ev   = chan_events(chan_b_in);   // RL21 RL20

  assign rd_std = cmd_valid_in && cmd_in == CMD_RD_STD;
  assign rd_flt = cmd_valid_in && cmd_in == CMD_RD_FLT;
  assign rd_cha = cmd_valid_in && cmd_in == CMD_RD_CHA;
  assign rd_chb = cmd_valid_in && cmd_in == CMD_RD_CHB;

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    state_d = state_q;

    // A read clears, but an event in the same cycle still sets its bit
    state_d.std_flags    = (rd_std ? 8'h00 : state_q.std_flags)
                           | std_ev;                     // RL22 RL24
    state_d.fault_events = (rd_flt ? 8'h00 : state_q.fault_events)
                           | fault_ev;                   // RL22 RL24
    state_d.cha_events   = (rd_cha ? 8'h00 : state_q.cha_events)
                           | cha_ev;                     // RL22 RL24
    state_d.chb_events   = (rd_chb ? 8'h00 : state_q.chb_events)
                           | chb_ev;                     // RL22 RL24

    // Channel reset pulse follows an out-of-range request
    state_d.cha_reset = chan_a_in.out_of_range;          // RL20
    state_d.chb_reset = chan_b_in.out_of_range;          // RL20

    // Command port: reads answer with the value before any clear
    state_d.rsp_valid = cmd_valid_in;
    state_d.rsp_data  = state_q.rsp_data;
    if (cmd_valid_in) begin
      if (cmd_in == CMD_RD_SUM) begin
        state_d.rsp_data = state_q.status_byte;
      end else if (cmd_in == CMD_RD_STD) begin
        state_d.rsp_data = state_q.std_flags;
      end else if (cmd_in == CMD_RD_FLT) begin
        state_d.rsp_data = state_q.fault_events;
      end else if (cmd_in == CMD_RD_CHA) begin
        state_d.rsp_data = state_q.cha_events;
      end else if (cmd_in == CMD_RD_CHB) begin
        state_d.rsp_data = state_q.chb_events;
      end else if (cmd_in == CMD_WR_STD_EN) begin
        state_d.std_enable = cmd_data_in;
        state_d.rsp_data   = cmd_data_in;
      end else if (cmd_in == CMD_WR_FLT_EN) begin
        state_d.fault_enable = cmd_data_in;              // RL23
        state_d.rsp_data     = cmd_data_in;
      end else if (cmd_in == CMD_WR_CHA_EN) begin
        state_d.cha_enable = cmd_data_in;                // RL23
        state_d.rsp_data   = cmd_data_in;
      end else if (cmd_in == CMD_WR_CHB_EN) begin
        state_d.chb_enable = cmd_data_in;                // RL23
        state_d.rsp_data   = cmd_data_in;
      end else if (cmd_in == CMD_WR_SRQ_EN) begin
        state_d.srq_enable = cmd_data_in;
        state_d.rsp_data   = cmd_data_in;
      end else if (cmd_in == CMD_RD_STD_EN) begin
        state_d.rsp_data = state_q.std_enable;
      end else if (cmd_in == CMD_RD_FLT_EN) begin
        state_d.rsp_data = state_q.fault_enable;         // RL23
      end else if (cmd_in == CMD_RD_CHA_EN) begin
        state_d.rsp_data = state_q.cha_enable;           // RL23
      end else if (cmd_in == CMD_RD_CHB_EN) begin
        state_d.rsp_data = state_q.chb_enable;           // RL23
      end else begin
        state_d.rsp_data = state_q.srq_enable;
      end
    end

    // Summary byte follows the registers it summarises
    state_d.status_byte          = 8'h00;
    state_d.status_byte[SUM_CHB] =
      |(state_d.chb_events & state_d.chb_enable);        // RL1
    state_d.status_byte[SUM_CHA] =
      |(state_d.cha_events & state_d.cha_enable);        // RL2
    state_d.status_byte[SUM_FLT] =
      |(state_d.fault_events & state_d.fault_enable);    // RL3
    state_d.status_byte[SUM_MSG] = msg_avail_in;         // RL4
    state_d.status_byte[SUM_STD] =
      |(state_d.std_flags & state_d.std_enable);         // RL5
    state_d.srq = |(state_d.status_byte & state_d.srq_enable
                    & ~(8'h01 << SUM_RQS));              // RL6
    state_d.status_byte[SUM_RQS] = state_d.srq;          // RL6
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q              <= '0;
      state_q.std_flags    <= STD_RESET;                 // RL11
      state_q.fault_events <= EVT_RESET;
      state_q.cha_events   <= EVT_RESET;
      state_q.chb_events   <= EVT_RESET;
      state_q.std_enable   <= MASK_RESET;
      state_q.fault_enable <= MASK_RESET;
      state_q.cha_enable   <= MASK_RESET;
      state_q.chb_enable   <= MASK_RESET;
      state_q.srq_enable   <= MASK_RESET;
    end else if (ce_in) begin
      state_q <= state_d;
    end
  end

  assign rsp_valid_out    = state_q.rsp_valid;
  assign rsp_data_out     = state_q.rsp_data;
  assign status_byte_out  = state_q.status_byte;
  assign srq_out          = state_q.srq;
  assign chan_a_reset_out = state_q.cha_reset;
  assign chan_b_reset_out = state_q.chb_reset;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  chb_summary_a: assert property (
    ce_in |=> status_byte_out[SUM_CHB] ==
              |(state_q.chb_events & state_q.chb_enable))  // RL1
    else $error("channel B summary bit wrong");
  cha_summary_a: assert property (
    ce_in |=> status_byte_out[SUM_CHA] ==
              |(state_q.cha_events & state_q.cha_enable))  // RL2
    else $error("channel A summary bit wrong");
  fault_summary_a: assert property (
    ce_in |=> status_byte_out[SUM_FLT] ==
              |(state_q.fault_events & state_q.fault_enable))  // RL3
    else $error("fault summary bit wrong");
  msg_summary_a: assert property (
    ce_in |=> status_byte_out[SUM_MSG] == $past(msg_avail_in))  // RL4
    else $error("message bit does not follow queue");
  std_summary_a: assert property (
    ce_in |=> status_byte_out[SUM_STD] ==
              |(state_q.std_flags & state_q.std_enable))  // RL5
    else $error("standard summary bit wrong");
  service_request_a: assert property (
    ce_in |=> srq_out == status_byte_out[SUM_RQS] &&
      srq_out == |(status_byte_out[5:0] & state_q.srq_enable[5:0])) // RL6
    else $error("service request wrong");
  opc_event_a: assert property (
    ce_in && opc_done_in |=> state_q.std_flags[STD_OPC])  // RL7
    else $error("operation complete not flagged");
  query_error_a: assert property (
    ce_in && talk_req_in && !msg_avail_in
    |=> state_q.std_flags[STD_QUERY])  // RL8
    else $error("talk with empty queue not flagged");
  power_on_a: assert property (
    $fell(rst_in) |-> state_q.std_flags[STD_PON])  // RL11
    else $error("power-on flag missing");
  code_map_a: assert property (
    ce_in && chan_a_in.code_valid && chan_a_in.code == 3'h3
    |=> state_q.cha_events[2])  // RL18
    else $error("channel A code 3 not mapped to bit 2");
  range_reset_a: assert property (
    ce_in && chan_b_in.out_of_range
    |=> chan_b_reset_out && state_q.chb_events[CH_RANGE])  // RL20
    else $error("out of range did not reset channel B");
  read_clear_a: assert property (
    ce_in && rd_cha && cha_ev == 8'h00
    |=> state_q.cha_events == 8'h00 && rsp_valid_out
        && rsp_data_out == $past(state_q.cha_events))  // RL22
    else $error("channel A read did not clear");
  sticky_bit_a: assert property (
    ce_in && !rd_flt && state_q.fault_events[0]
    |=> state_q.fault_events[0])  // RL24
    else $error("fault bit lost without read");
  mask_readback_a: assert property (
    ce_in && cmd_valid_in && cmd_in == CMD_WR_FLT_EN
    ##1 ce_in && cmd_valid_in && cmd_in == CMD_RD_FLT_EN
    |=> rsp_data_out == $past(cmd_data_in, 2))  // RL23
    else $error("fault mask read back wrong");
  exec_event_a: assert property (
    ce_in && exec_err_in |=> state_q.std_flags[STD_EXEC])  // RL9
    else $error("execution error not flagged");
  syntax_event_a: assert property (
    ce_in && syntax_err_in |=> state_q.std_flags[STD_CMD])  // RL10
    else $error("syntax error not flagged");
  power_on_hold_a: assert property (
    ce_in && !rd_std && state_q.std_flags[STD_PON]
    |=> state_q.std_flags[STD_PON])  // RL11
    else $error("power-on flag lost without read");
  drive_fail_a: assert property (
    ce_in && fault_in.drive_fail |=> state_q.fault_events[0])  // RL12
    else $error("drive supply failure not flagged");
  hold_fail_a: assert property (
    ce_in && fault_in.hold_fail |=> state_q.fault_events[4])  // RL12
    else $error("holding supply failure not flagged");
  over_temp_a: assert property (
    ce_in && fault_in.over_temp |=> state_q.fault_events[1])  // RL13
    else $error("over-temperature not flagged");
  restart_wait_a: assert property (
    ce_in && fault_in.restart_wait |=> state_q.fault_events[2])  // RL14
    else $error("restart wait not flagged");
  config_change_a: assert property (
    ce_in && fault_in.config_change |=> state_q.fault_events[3])  // RL15
    else $error("configuration change not flagged");
  nvm_fail_a: assert property (
    ce_in && fault_in.nvm_fail |=> state_q.fault_events[5])  // RL16
    else $error("settings memory failure not flagged");
  unknown_cha_a: assert property (
    ce_in && fault_in.unknown_a |=> state_q.fault_events[6])  // RL17
    else $error("unknown channel A instrument not flagged");
  unknown_chb_a: assert property (
    ce_in && fault_in.unknown_b |=> state_q.fault_events[7])  // RL17
    else $error("unknown channel B instrument not flagged");
  positioned_a: assert property (
    ce_in && chan_a_in.positioned
    |=> state_q.cha_events[CH_POSITIONED])  // RL19
    else $error("channel A positioning not flagged");
  chb_layout_a: assert property (
    ce_in && chan_b_in.code_valid && chan_b_in.code == 3'h5
    |=> state_q.chb_events[4])  // RL21
    else $error("channel B code 5 not mapped to bit 4");
  cha_range_a: assert property (
    ce_in && chan_a_in.out_of_range
    |=> chan_a_reset_out && state_q.cha_events[CH_RANGE])  // RL20
    else $error("out of range did not reset channel A");
  std_clear_a: assert property (
    ce_in && rd_std && std_ev == 8'h00
    |=> state_q.std_flags == 8'h00)  // RL22
    else $error("standard event read did not clear");

  srq_raised_c: cover property (ce_in ##1 $rose(srq_out));
  read_clear_c: cover property (ce_in && rd_std && std_ev != 8'h00);
  range_reset_c: cover property ($rose(chan_a_reset_out));
  code_map_c: cover property (
    ce_in && chan_b_in.code_valid && chan_b_in.code == 3'h2);
  status_read_c: cover property (
    ce_in && cmd_valid_in && cmd_in == CMD_RD_SUM);

endmodule

// ### srr_host_model.sv
`timescale 1ns/1ns

module srr_host_model
  import srr_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  output srr_cmd_type      cmd_out,
  output logic             cmd_valid_out,
  output logic [7:0]       cmd_data_out
);
  int seed = 17326;

  initial begin
    cmd_valid_out = 1'b0;
    cmd_out       = CMD_RD_STD;
    cmd_data_out  = 8'h00;
  end

  // -------------------------------------------------------------------
  // Random command stream, back to back, one-cycle strobes
  // -------------------------------------------------------------------
  always @(negedge clk_in) begin
    cmd_valid_out <= !rst_in && (($random(seed) & 3) != 0);
    cmd_out       <= srr_cmd_type'(4'({$random(seed)} % 15));
    cmd_data_out  <= 8'($random(seed));
  end
endmodule

// ### status_reporting_registers_tb.sv
`timescale 1ns/1ns

module status_reporting_registers_tb;
  import srr_pkg::*;

  logic          clk_in = 1'b0;
  logic          rst_in = 1'b1;
  logic          ce_in  = 1'b1;
  logic          opc = 1'b0;
  logic          talk = 1'b0;
  logic          msg = 1'b0;
  logic          exe = 1'b0;
  logic          syn = 1'b0;
  srr_fault_type fault = '0;
  srr_chan_type  cha_in = '0;
  srr_chan_type  chb_in = '0;
  srr_cmd_type   cmd;
  logic          cmd_valid;
  logic [7:0]    cmd_data;
  logic          rsp_valid;
  logic [7:0]    rsp_data;
  logic [7:0]    status_byte;
  logic          srq;
  logic          a_rst;
  logic          b_rst;
  logic [7:0]    m_std, m_flt, m_cha, m_chb, m_sb, m_rsp;
  logic [7:0]    e_std, e_flt, e_cha, e_chb, e_srq;
  logic          m_rv, m_ar, m_br;
  logic          live = 1'b0;
  int            error_cnt = 0;
  int            cmp_count = 0;
  int            seed = 17326;

  always #50 clk_in = ~clk_in;

  srr_host_model host_u (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .cmd_out       (cmd),
    .cmd_valid_out (cmd_valid),
    .cmd_data_out  (cmd_data)
  );

  srr_top dut_u (
    .clk_in           (clk_in),
    .rst_in           (rst_in),
    .ce_in            (ce_in),
    .cmd_valid_in     (cmd_valid),
    .cmd_in           (cmd),
    .cmd_data_in      (cmd_data),
    .opc_done_in      (opc),
    .talk_req_in      (talk),
    .msg_avail_in     (msg),
    .exec_err_in      (exe),
    .syntax_err_in    (syn),
    .fault_in         (fault),
    .chan_a_in        (cha_in),
    .chan_b_in        (chb_in),
    .rsp_valid_out    (rsp_valid),
    .rsp_data_out     (rsp_data),
    .status_byte_out  (status_byte),
    .srq_out          (srq),
    .chan_a_reset_out (a_rst),
    .chan_b_reset_out (b_rst)
  );

  // -------------------------------------------------------------------
  // Reference model
  // -------------------------------------------------------------------
  function automatic logic [7:0] chan_bits(srr_chan_type c);
    logic [7:0] b;
    b = 8'h00;
    if (c.code_valid && c.code >= 3'h1 && c.code <= 3'h5)
      b[c.code - 3'h1] = 1'b1;
    b[5] = c.positioned;
    b[6] = c.out_of_range;
    return b;
  endfunction

  always @(posedge clk_in) begin
    live <= 1'b1;
    if (rst_in) begin
      {m_flt, m_cha, m_chb, m_sb, m_rsp} = '0;
      {e_std, e_flt, e_cha, e_chb, e_srq} = '0;
      {m_rv, m_ar, m_br} = '0;
      m_std = 8'h80;
    end else if (ce_in) begin
      m_rv = cmd_valid;
      if (cmd_valid) begin
        case (cmd)
          CMD_RD_STD:    begin m_rsp = m_std; m_std = 8'h00; end
          CMD_RD_FLT:    begin m_rsp = m_flt; m_flt = 8'h00; end
          CMD_RD_CHA:    begin m_rsp = m_cha; m_cha = 8'h00; end
          CMD_RD_CHB:    begin m_rsp = m_chb; m_chb = 8'h00; end
          CMD_WR_STD_EN: e_std = cmd_data;
          CMD_WR_FLT_EN: e_flt = cmd_data;
          CMD_WR_CHA_EN: e_cha = cmd_data;
          CMD_WR_CHB_EN: e_chb = cmd_data;
          CMD_WR_SRQ_EN: e_srq = cmd_data;
          CMD_RD_STD_EN: m_rsp = e_std;
          CMD_RD_FLT_EN: m_rsp = e_flt;
          CMD_RD_CHA_EN: m_rsp = e_cha;
          CMD_RD_CHB_EN: m_rsp = e_chb;
          CMD_RD_SRQ_EN: m_rsp = e_srq;
          default:       m_rsp = m_sb;
        endcase
        if (cmd >= CMD_WR_STD_EN && cmd <= CMD_WR_SRQ_EN)
          m_rsp = cmd_data;
      end
      m_std |= {2'b00, syn, exe, 1'b0, talk & ~msg, 1'b0, opc};
      m_flt |= fault;
      m_cha |= chan_bits(cha_in);
      m_chb |= chan_bits(chb_in);
      m_ar = cha_in.out_of_range;
      m_br = chb_in.out_of_range;
      m_sb = 8'h00;
      m_sb[1] = |(m_chb & e_chb);
      m_sb[2] = |(m_cha & e_cha);
      m_sb[3] = |(m_flt & e_flt);
      m_sb[4] = msg;
      m_sb[5] = |(m_std & e_std);
      m_sb[6] = |(m_sb & e_srq & 8'hbf);
    end
  end

  // -------------------------------------------------------------------
  // Comparison and verdict
  // -------------------------------------------------------------------
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(negedge clk_in) begin
    if (live) begin
      check("status_byte", status_byte, m_sb);
      check("srq", {7'h00, srq}, {7'h00, m_sb[6]});
      check("rsp_valid", {7'h00, rsp_valid}, {7'h00, m_rv});
      check("rsp_data", rsp_data, m_rsp);
      check("chan_reset", {6'h00, a_rst, b_rst}, {6'h00, m_ar, m_br});
    end
  end

  // -------------------------------------------------------------------
  // Stimulus: sparse random events, clock enable gaps, mid-run reset
  // -------------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clk_in);
    rst_in = 1'b0;
    for (int i = 0; i < 4000; i++) begin
      @(negedge clk_in);
      rst_in = (i >= 2000 && i < 2002);
      ce_in  = (($random(seed) & 15) != 0);
      opc    = (($random(seed) & 7) == 0);
      talk   = (($random(seed) & 7) == 0);
      msg    = (($random(seed) & 3) == 0);
      exe    = (($random(seed) & 7) == 0);
      syn    = (($random(seed) & 7) == 0);
      fault  = 8'($random(seed) & $random(seed) & $random(seed));
      cha_in = 6'($random(seed) & $random(seed));
      chb_in = 6'($random(seed) & $random(seed));
    end
    results();
  end
endmodule
